// file: cicp_pkg.sv
// Contract
// - Bits 31 to 26 read zero, ignore writes.
// - Card access sets status bit 25.
// - Reading the register clears bit 25.
// - Bit 24 shows the card clock is altered.
// - Bits 23 to 17 read zero.
// - Unlock bit 16 gates policy bit 0.
// - Policy zero lets idle stop the clock.
// - Policy one slows clock by sixteen instead.
// - Bits 15 to 1 read zero.
// - Register at offset 0x20, resets to zero.
// - Alter clock only when socket is idle.
`default_nettype none
package cicp_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IRQ_W  = 2;

	localparam logic [7:0] OFF_PWR   = 8'h20;
	localparam logic [7:0] OFF_ISTAT = 8'h24;
	localparam logic [7:0] OFF_IMASK = 8'h28;
	localparam logic [7:0] OFF_SCTL  = 8'h2C;

	localparam int unsigned BIT_ACCESS   = 25;
	localparam int unsigned BIT_ALTERED  = 24;
	localparam int unsigned BIT_UNLOCK   = 16;
	localparam int unsigned BIT_POLICY   = 0;
	localparam int unsigned BIT_STOPGATE = 0;
	localparam int unsigned IRQ_ACCESS   = 0;
	localparam int unsigned IRQ_MODE     = 1;

	localparam logic [31:0] PWR_RST  = 32'h0000_0000;
	localparam logic [31:0] SCTL_RST = 32'h0000_0000;
	localparam logic [1:0]  IRQ_RST  = 2'h0;

	localparam int unsigned SLOW_DIV      = 16;
	localparam logic [3:0]  SLOW_CNT_LAST = 4'(SLOW_DIV - 1);

	typedef enum logic [2:0] {
		ST_RUN  = 3'h1,
		ST_STOP = 3'h2,
		ST_SLOW = 3'h4
	} cicp_clk_state_e;

endpackage
`default_nettype wire

// file: cicp_slow_tick.sv
`timescale 1ns/1ps
`default_nettype none
module cicp_slow_tick
	import cicp_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	output var  logic tick_o
);

	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic       next_tick;

	// Free running divider, one tick in every sixteen cycles.
	always_comb begin
		next_cnt  = cnt + 4'h1;
		next_tick = (cnt == SLOW_CNT_LAST);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt    <= 4'h0;
			tick_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			tick_o <= next_tick;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	tick_spacing_a: assert property (tick_o |=> !tick_o [*8])
		else $error("Divider tick came too early.");

endmodule
`default_nettype wire

// file: cicp_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cicp_irq_ctrl
	import cicp_pkg::*;
(
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic [IRQ_W-1:0] event_i,
	input  wire logic             stat_wr_i,
	input  wire logic             mask_wr_i,
	input  wire logic [IRQ_W-1:0] wdata_i,
	output var  logic [IRQ_W-1:0] status_o,
	output var  logic [IRQ_W-1:0] mask_o,
	output var  logic             irq_o
);

	logic [IRQ_W-1:0] next_status;
	logic [IRQ_W-1:0] next_mask;
	logic             next_irq;

	// Write one clears a bit; a new event in the same cycle wins.
	always_comb begin
		next_status = status_o;
		if (stat_wr_i) begin
			next_status = next_status & ~wdata_i;
		end
		next_status = next_status | event_i;
		next_mask   = mask_wr_i ? wdata_i : mask_o;
		next_irq    = |(next_status & next_mask);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= IRQ_RST;
			mask_o   <= IRQ_RST;
			irq_o    <= 1'b0;
		end else begin
			status_o <= next_status;
			mask_o   <= next_mask;
			irq_o    <= next_irq;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	event_wins_a: assert property (|event_i |=> |status_o)
		else $error("Event lost against a status clear.");
	irq_level_a: assert property (irq_o == |(status_o & mask_o))
		else $error("Interrupt level disagrees with status and mask.");

endmodule
`default_nettype wire

// file: cicp_power_ctrl.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cicp_power_ctrl
	import cicp_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output var  logic [DATA_W-1:0] reg_rdata_o,
	input  wire logic              card_access_i,
	input  wire logic              socket_idle_i,
	input  wire logic              host_stop_prep_i,
	output var  logic              card_clk_en_o,
	output var  logic              clock_altered_o,
	output var  logic              irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Register decode.

	logic wr_pwr;
	logic rd_pwr;
	logic wr_istat;
	logic wr_imask;
	logic wr_sctl;

	always_comb begin
		wr_pwr   = reg_wr_i && (reg_addr_i == OFF_PWR);
		rd_pwr   = reg_rd_i && (reg_addr_i == OFF_PWR);
		wr_istat = reg_wr_i && (reg_addr_i == OFF_ISTAT);
		wr_imask = reg_wr_i && (reg_addr_i == OFF_IMASK);
		wr_sctl  = reg_wr_i && (reg_addr_i == OFF_SCTL);
	end

	////////////////////////////////////////////////////////////////////////////
	// Software control bits.

	logic clock_policy_unlock;
	logic idle_clock_policy;
	logic idle_stop_gate;
	logic next_unlock;
	logic next_policy;
	logic next_stop_gate;

	// Only bits 16 and 0 store; all other written bits are dropped.
	always_comb begin
		next_unlock    = clock_policy_unlock;
		next_policy    = idle_clock_policy;
		next_stop_gate = idle_stop_gate;
		if (wr_pwr) begin
			next_unlock = reg_wdata_i[BIT_UNLOCK];
			next_policy = reg_wdata_i[BIT_POLICY];
		end
		if (wr_sctl) begin
			next_stop_gate = reg_wdata_i[BIT_STOPGATE];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clock_policy_unlock <= PWR_RST[BIT_UNLOCK];
			idle_clock_policy   <= PWR_RST[BIT_POLICY];
			idle_stop_gate      <= SCTL_RST[BIT_STOPGATE];
		end else begin
			clock_policy_unlock <= next_unlock;
			idle_clock_policy   <= next_policy;
			idle_stop_gate      <= next_stop_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Card access status, cleared by a read of the register.

	logic card_access_seen;
	logic next_access_seen;

	// A read clears the flag after returning it; a new access wins.
	always_comb begin
		next_access_seen = card_access_seen;
		if (rd_pwr) begin
			next_access_seen = 1'b0;
		end
		if (card_access_i) begin
			next_access_seen = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			card_access_seen <= PWR_RST[BIT_ACCESS];
		end else begin
			card_access_seen <= next_access_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Idle clock state machine.

	cicp_clk_state_e state;
	cicp_clk_state_e next_state;
	logic            idle_ok;
	logic            slow_sel;
	logic            slow_tick;
	logic            next_clk_en;
	logic            next_altered;

	cicp_slow_tick u_slow_tick (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_o    (slow_tick)
	);

	always_comb begin
		idle_ok  = socket_idle_i && (idle_stop_gate || host_stop_prep_i);
		slow_sel = clock_policy_unlock && idle_clock_policy;
		case (state)
			ST_RUN: begin
				if (idle_ok) begin
					next_state = slow_sel ? ST_SLOW : ST_STOP;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_STOP: begin
				if (!idle_ok) begin
					next_state = ST_RUN;
				end else if (slow_sel) begin
					next_state = ST_SLOW;
				end else begin
					next_state = ST_STOP;
				end
			end
			ST_SLOW: begin
				if (!idle_ok) begin
					next_state = ST_RUN;
				end else if (!slow_sel) begin
					next_state = ST_STOP;
				end else begin
					next_state = ST_SLOW;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
		case (next_state)
			ST_RUN:  next_clk_en = 1'b1;
			ST_STOP: next_clk_en = 1'b0;
			ST_SLOW: next_clk_en = slow_tick;
			default: next_clk_en = 1'b1;
		endcase
		next_altered = (next_state != ST_RUN);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state           <= ST_RUN;
			card_clk_en_o   <= 1'b1;
			clock_altered_o <= PWR_RST[BIT_ALTERED];
		end else begin
			state           <= next_state;
			card_clk_en_o   <= next_clk_en;
			clock_altered_o <= next_altered;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask.

	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	always_comb begin
		irq_events             = '0;
		irq_events[IRQ_ACCESS] = card_access_i;
		irq_events[IRQ_MODE]   = (next_altered != clock_altered_o);
	end

	cicp_irq_ctrl u_irq_ctrl (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.event_i   (irq_events),
		.stat_wr_i (wr_istat),
		.mask_wr_i (wr_imask),
		.wdata_i   (reg_wdata_i[IRQ_W-1:0]),
		.status_o  (irq_status),
		.mask_o    (irq_mask),
		.irq_o     (irq_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read data, valid the cycle after the read strobe.

	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] next_rdata;

	// Unlisted bits and unmapped addresses read zero.
	always_comb begin
		rd_word = '0;
		case (reg_addr_i)
			OFF_PWR: begin
				rd_word[BIT_ACCESS]  = card_access_seen;
				rd_word[BIT_ALTERED] = clock_altered_o;
				rd_word[BIT_UNLOCK]  = clock_policy_unlock;
				rd_word[BIT_POLICY]  = idle_clock_policy;
			end
			OFF_ISTAT: rd_word[IRQ_W-1:0] = irq_status;
			OFF_IMASK: rd_word[IRQ_W-1:0] = irq_mask;
			OFF_SCTL:  rd_word[BIT_STOPGATE] = idle_stop_gate;
			default:   rd_word = '0;
		endcase
		next_rdata = reg_rd_i ? rd_word : '0;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	top_bits_zero_a: assert property (rd_pwr |=> reg_rdata_o[31:26] == 6'h0)
		else $error("Top reserved bits read nonzero.");
	access_sets_a: assert property (card_access_i |=> card_access_seen)
		else $error("Card access did not set the status flag.");
	read_clears_a: assert property (rd_pwr && !card_access_i |=> !card_access_seen)
		else $error("Read did not clear the access flag.");
	altered_idle_a: assert property (idle_ok |=> clock_altered_o)
		else $error("Clock not reported altered while idle.");
	mid_bits_zero_a: assert property (rd_pwr |=> reg_rdata_o[23:17] == 7'h0)
		else $error("Middle reserved bits read nonzero.");
	slow_needs_unlock_a: assert property (state == ST_SLOW |-> $past(clock_policy_unlock)
		&& $past(idle_clock_policy))
		else $error("Slow mode entered without unlock and policy.");
	stop_no_clock_a: assert property (state == ST_STOP |-> !card_clk_en_o)
		else $error("Card clock runs in stop mode.");
	slow_spacing_a: assert property (state == ST_SLOW && card_clk_en_o |=>
		(!card_clk_en_o || state != ST_SLOW) [*8])
		else $error("Slowed clock pulses too often.");
	low_bits_zero_a: assert property (rd_pwr |=> reg_rdata_o[15:1] == 15'h0)
		else $error("Low reserved bits read nonzero.");
	other_addr_keeps_a: assert property (reg_wr_i && reg_addr_i != OFF_PWR |=>
		clock_policy_unlock == $past(clock_policy_unlock))
		else $error("Write elsewhere changed the unlock bit.");
	busy_runs_a: assert property (!socket_idle_i |=> state == ST_RUN && card_clk_en_o)
		else $error("Clock altered while socket busy.");
	locked_stops_a: assert property (!clock_policy_unlock && idle_ok |=> state == ST_STOP)
		else $error("Locked policy did not stop the clock.");

	stop_seen_c: cover property (state == ST_RUN ##1 state == ST_STOP);
	slow_seen_c: cover property (state == ST_SLOW && card_clk_en_o);
	clear_race_c: cover property (rd_pwr && card_access_i);
	mode_irq_c:   cover property (irq_status[IRQ_MODE] && irq_mask[IRQ_MODE]);
	slow_exit_c:  cover property (state == ST_SLOW ##1 state == ST_RUN);

endmodule
`default_nettype wire

// file: cicp_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// Card side: raises access one cycle after the request, for as long as it is held, and reports idle only while idle is requested and no access runs.
module cicp_card_model (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic access_req_i,
	input  wire logic idle_req_i,
	output var  logic card_access_o,
	output var  logic socket_idle_o
);
	logic next_access;

	always_comb begin
		next_access = access_req_i;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			card_access_o <= 1'b0;
		end else begin
			card_access_o <= next_access;
		end
	end

	// A card in the middle of an access is never idle.
	assign socket_idle_o = idle_req_i & ~card_access_o;
endmodule
`default_nettype wire

// file: card_clock_idle_power_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module card_clock_idle_power_ctrl_tb
	import cicp_pkg::*;
;
	logic              ref_clk_i, rst_i, reg_wr, reg_rd, acc_req, idle_req, prep;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, rdata_o, d;
	logic              acc, idle, clk_en, altered, irq;
	logic [7:0]        cnt;
	int                fails, tests_run, cyc;

	cicp_card_model u_card (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .access_req_i(acc_req),
		.idle_req_i(idle_req), .card_access_o(acc), .socket_idle_o(idle));

	cicp_power_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata_o),
		.card_access_i(acc), .socket_idle_i(idle), .host_stop_prep_i(prep),
		.card_clk_en_o(clk_en), .clock_altered_o(altered), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk_i);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk_i);
		reg_rd   <= 1'b0;
		#1 v = rdata_o;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic results();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(OFF_PWR, d);
		chk(d, 32'h0000_0000);
		chk({31'h0, clk_en}, 32'h0000_0001);
		chk({31'h0, altered}, 32'h0000_0000);
		rd(8'h40, d);
		chk(d, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_reserved();
		wr(OFF_PWR, 32'hFFFF_FFFF);
		rd(OFF_PWR, d);
		chk(d, 32'h0001_0001);
		wr(OFF_PWR, 32'h0000_0000);
		rd(OFF_PWR, d);
		chk(d, 32'h0000_0000);
		$display("test reserved done");
	endtask

	task automatic t_access();
		wr(OFF_ISTAT, 32'h0000_0003);
		wr(OFF_IMASK, 32'h0000_0001);
		@(posedge ref_clk_i);
		acc_req <= 1'b1;
		@(posedge ref_clk_i);
		acc_req <= 1'b0;
		wait_n(3);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(OFF_PWR, d);
		chk(d, 32'h0200_0000);
		rd(OFF_PWR, d);
		chk(d, 32'h0000_0000);
		@(posedge ref_clk_i);
		acc_req <= 1'b1;
		rd(OFF_PWR, d);
		chk(d, 32'h0000_0000);
		@(posedge ref_clk_i);
		acc_req <= 1'b0;
		wait_n(3);
		rd(OFF_PWR, d);
		chk(d, 32'h0200_0000);
		wr(OFF_ISTAT, 32'h0000_0001);
		wait_n(2);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(OFF_IMASK, 32'h0000_0000);
		$display("test access done");
	endtask

	task automatic t_stop();
		wr(OFF_SCTL, 32'h0000_0001);
		rd(OFF_SCTL, d);
		chk(d, 32'h0000_0001);
		wr(OFF_PWR, 32'h0000_0001);
		wait_n(4);
		chk({31'h0, altered}, 32'h0000_0000);
		@(posedge ref_clk_i);
		idle_req <= 1'b1;
		wait_n(4);
		cnt = 8'h00;
		repeat (32) begin
			cnt = cnt + {7'h0, clk_en};
			wait_n(1);
		end
		chk({24'h0, cnt}, 32'h0000_0000);
		chk({31'h0, altered}, 32'h0000_0001);
		rd(OFF_PWR, d);
		chk(d, 32'h0100_0001);
		@(posedge ref_clk_i);
		idle_req <= 1'b0;
		wait_n(4);
		chk({30'h0, altered, clk_en}, 32'h0000_0001);
		$display("test stop done");
	endtask

	task automatic t_slow();
		wr(OFF_PWR, 32'h0001_0001);
		@(posedge ref_clk_i);
		idle_req <= 1'b1;
		wait_n(4);
		cnt = 8'h00;
		repeat (64) begin
			cnt = cnt + {7'h0, clk_en};
			wait_n(1);
		end
		chk({24'h0, cnt}, 32'h0000_0004);
		chk({31'h0, altered}, 32'h0000_0001);
		@(posedge ref_clk_i);
		idle_req <= 1'b0;
		wait_n(4);
		$display("test slow done");
	endtask

	task automatic t_gate();
		wr(OFF_SCTL, 32'h0000_0000);
		wr(OFF_PWR, 32'h0000_0000);
		@(posedge ref_clk_i);
		idle_req <= 1'b1;
		wait_n(6);
		chk({30'h0, altered, clk_en}, 32'h0000_0001);
		@(posedge ref_clk_i);
		prep <= 1'b1;
		wait_n(4);
		chk({30'h0, altered, clk_en}, 32'h0000_0002);
		@(posedge ref_clk_i);
		prep     <= 1'b0;
		idle_req <= 1'b0;
		wait_n(4);
		chk({30'h0, altered, clk_en}, 32'h0000_0001);
		$display("test gate done");
	endtask

	task automatic t_irq();
		wr(OFF_ISTAT, 32'h0000_0003);
		wr(OFF_IMASK, 32'h0000_0002);
		rd(OFF_IMASK, d);
		chk(d, 32'h0000_0002);
		@(posedge ref_clk_i);
		prep     <= 1'b1;
		idle_req <= 1'b1;
		wait_n(4);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(OFF_ISTAT, d);
		chk(d, 32'h0000_0002);
		wr(OFF_ISTAT, 32'h0000_0002);
		wait_n(1);
		chk({31'h0, irq}, 32'h0000_0000);
		@(posedge ref_clk_i);
		prep     <= 1'b0;
		idle_req <= 1'b0;
		wait_n(3);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(OFF_ISTAT, 32'h0000_0002);
		wr(OFF_IMASK, 32'h0000_0000);
		rd(OFF_ISTAT, d);
		chk(d, 32'h0000_0000);
		$display("test irq done");
	endtask

	task automatic t_midreset();
		wr(OFF_PWR, 32'h0001_0001);
		wr(OFF_SCTL, 32'h0000_0001);
		@(posedge ref_clk_i);
		idle_req <= 1'b1;
		wait_n(4);
		chk({31'h0, altered}, 32'h0000_0001);
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		wait_n(2);
		chk({30'h0, altered, clk_en}, 32'h0000_0001);
		@(posedge ref_clk_i);
		idle_req <= 1'b0;
		rst_i    <= 1'b0;
		rd(OFF_PWR, d);
		chk(d, 32'h0000_0000);
		rd(OFF_SCTL, d);
		chk(d, 32'h0000_0000);
		$display("test midreset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fails     = 0;
		tests_run = 0;
		cyc       = 0;
		rst_i     = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		acc_req   = 1'b0;
		idle_req  = 1'b0;
		prep      = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_reserved();
		t_access();
		t_stop();
		t_slow();
		t_gate();
		t_irq();
		t_midreset();
		results();
	end
endmodule
`default_nettype wire
